// ===== core/rx_desc_memory.sv
// Local descriptor memory with one write and one read port.
`timescale 1ns/1ps
`default_nettype none
module rx_desc_memory
  import rx_desc_pkg::*;
(
  // Clock and clock enable.
  input wire logic mclk,
  input wire logic clk_en,
  // Write port.
  input wire logic wr_en,
  input wire logic [mem_index_width+1:0] wr_addr,
  input wire logic [31:0] wr_data,
  // Read port.
  input wire logic [mem_index_width+1:0] rd_addr,
  output logic [31:0] rd_data
);
  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [31:0] mem [0:mem_depth-1];

  always_ff @(posedge mclk)
  begin
    if (clk_en && wr_en)
    begin
      mem[wr_addr[mem_index_width+1:0]] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule : rx_desc_memory
`default_nettype wire

// ===== core/rx_descriptor_writeback.sv
// Receive descriptor walker and writeback engine with local descriptor memory.
`timescale 1ns/1ps
`default_nettype none
module rx_descriptor_writeback
  import rx_desc_pkg::*;
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Channel control.
  input wire logic [31:0] head_pointer,
  input wire logic start_channel,
  input wire logic teardown_request,
  input wire logic [15:0] receive_offset_value,
  input wire logic keep_error_frames,
  input wire logic keep_short_frames,
  input wire logic keep_control_frames,
  input wire logic keep_all_frames,
  input wire logic crc_retained,
  // Host descriptor memory port.
  input wire logic host_wr_en,
  input wire logic [31:0] host_addr,
  input wire logic [31:0] host_wr_data,
  output logic [31:0] host_rd_data,
  // Frame byte stream from the MAC receive path.
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic [9:0] rx_status,
  output logic rx_ready,
  // Buffer write to system memory.
  output logic buf_wr_en,
  output logic [31:0] buf_wr_addr,
  output logic [7:0] buf_wr_data,
  // Status.
  output logic channel_active,
  output logic channel_halted,
  output logic teardown_done,
  output logic packet_done
);
  // rx_status bit order: jabber, oversize, fragment, undersized, control,
  // overrun, symbol, alignment, checksum, address miss (bit 9 down to 0).

  // ==========================================================================
  // Local descriptor memory
  // ==========================================================================
  logic eng_wr;
  logic [31:0] eng_wr_data;
  logic [mem_index_width+1:0] eng_wr_idx;
  logic [mem_index_width+1:0] rd_idx;
  logic [31:0] rd_word;

  engine_state_type state_q;
  logic [31:0] desc_q;
  logic [31:0] sop_desc_q;
  logic [31:0] next_q;
  logic [31:0] buf_ptr_q;
  logic [15:0] buf_size_q;
  logic [15:0] buf_count_q;
  logic [15:0] pkt_count_q;
  logic [15:0] offset_q;
  logic first_buf_q;
  logic last_byte_q;
  logic [9:0] status_q;

  function automatic logic [mem_index_width+1:0] word_index(input logic [31:0] addr,
                                                            input logic [1:0] word);
    word_index = addr[mem_index_width+3:2] + {{mem_index_width{1'b0}}, word};
  endfunction : word_index

  // Host writes take priority; the engine only writes in st_close_buf, st_write_sop, st_advance and st_teardown.
  wire host_write = host_wr_en;
  wire [mem_index_width+1:0] host_idx = host_addr[mem_index_width+3:2];
  wire mem_wr = host_write | eng_wr;
  wire [mem_index_width+1:0] mem_wr_idx = host_write ? host_idx : eng_wr_idx;
  wire [31:0] mem_wr_data = host_write ? host_wr_data : eng_wr_data;

  rx_desc_memory desc_mem (
    .mclk(mclk),
    .clk_en(clk_en),
    .wr_en(mem_wr),
    .wr_addr(mem_wr_idx),
    .wr_data(mem_wr_data),
    .rd_addr(rd_idx),
    .rd_data(rd_word)
  );

  // ==========================================================================
  // Engine decode
  // ==========================================================================
  wire in_fetch_next = (state_q == st_fetch_next);
  wire in_fetch_len = (state_q == st_fetch_len);
  wire in_fill = (state_q == st_fill);
  wire engine_reads = in_fetch_next | in_fetch_len;
  wire [1:0] read_word = in_fetch_next ? word_next : word_offlen;
  assign rd_idx = engine_reads ? word_index(desc_q, read_word) : host_idx;

  wire byte_take = in_fill & rx_valid;
  wire [15:0] count_inc = buf_count_q + 16'h0001;
  wire [15:0] room = buf_size_q - (first_buf_q ? offset_q : 16'h0000);
  wire buf_full = byte_take & (count_inc == room);
  wire next_is_null = (next_q == null_pointer);
  wire [9:0] kept_status = {
    rx_status[9:7] & {3{keep_error_frames}},
    rx_status[6] & keep_short_frames,
    rx_status[5] & keep_control_frames,
    rx_status[4],
    rx_status[3:1] & {3{keep_error_frames}},
    rx_status[0] & keep_all_frames};

  // Flag half of the fourth word for each written descriptor.
  wire [15:0] last_flags = {first_buf_q, 1'b1, 1'b0, next_is_null, 12'h000};
  wire [15:0] mid_flags = {first_buf_q, 1'b0, 1'b0, 1'b0, 12'h000};
  wire [15:0] sop_flags = {1'b1, last_byte_q & (sop_desc_q == desc_q), 1'b0,
                           last_byte_q & (sop_desc_q == desc_q) & next_is_null,
                           1'b0, crc_retained, status_q};
  wire [15:0] sop_offset = offset_q;

  always_comb
  begin
    eng_wr = 1'b0;
    eng_wr_idx = word_index(desc_q, word_offlen);
    eng_wr_data = 32'h0000_0000;
    unique case (state_q)
      st_close_buf:
      begin
        // Non-start buffers: flags with a zero length half; start buffer waits for packet end.
        eng_wr = ~first_buf_q;
        eng_wr_idx = word_index(desc_q, word_flglen);
        eng_wr_data = {(last_byte_q ? last_flags : mid_flags), 16'h0000};
      end
      st_write_sop:
      begin
        eng_wr = 1'b1;
        eng_wr_idx = word_index(sop_desc_q, word_flglen);
        eng_wr_data = {sop_flags, pkt_count_q};
      end
      st_advance:
      begin
        // Buffer length overwritten; offset recorded on start descriptor only.
        eng_wr = 1'b1;
        eng_wr_idx = word_index(desc_q, word_offlen);
        eng_wr_data = {(first_buf_q ? sop_offset : 16'h0000), buf_count_q};
      end
      st_teardown:
      begin
        eng_wr = 1'b1;
        eng_wr_idx = word_index(desc_q, word_flglen);
        eng_wr_data = {16'h0000, 16'h0000} | (32'h0000_0001 << bit_teardown);
      end
      default:
      begin
        eng_wr = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Engine state machine
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= st_idle;
      desc_q <= null_pointer;
      sop_desc_q <= null_pointer;
      next_q <= null_pointer;
      buf_ptr_q <= null_pointer;
      buf_size_q <= 16'h0000;
      buf_count_q <= 16'h0000;
      pkt_count_q <= 16'h0000;
      offset_q <= offset_reset;
      first_buf_q <= 1'b1;
      last_byte_q <= 1'b0;
      status_q <= 10'h000;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        st_idle, st_halted:
        begin
          if (start_channel && head_pointer != null_pointer)
          begin
            desc_q <= head_pointer;
            first_buf_q <= 1'b1;
            state_q <= st_fetch_next;
          end
        end
        st_fetch_next:
        begin
          // Pointer read early, before the fill, so only a null replaced before now is honoured.
          next_q <= rd_word;
          buf_ptr_q <= null_pointer;
          state_q <= teardown_request ? st_teardown : st_fetch_len;
        end
        st_fetch_len:
        begin
          buf_size_q <= rd_word[15:0];
          buf_count_q <= 16'h0000;
          last_byte_q <= 1'b0;
          if (first_buf_q)
          begin
            offset_q <= receive_offset_value;
            pkt_count_q <= 16'h0000;
          end
          state_q <= st_fill;
        end
        st_fill:
        begin
          if (teardown_request && first_buf_q && buf_count_q == 16'h0000)
          begin
            state_q <= st_teardown;
          end
          else if (byte_take)
          begin
            buf_count_q <= count_inc;
            pkt_count_q <= pkt_count_q + 16'h0001;
            if (rx_last)
            begin
              status_q <= kept_status;
            end
            if (rx_last || buf_full)
            begin
              last_byte_q <= rx_last;
              state_q <= st_close_buf;
            end
          end
        end
        st_close_buf:
        begin
          if (first_buf_q)
          begin
            sop_desc_q <= desc_q;
          end
          state_q <= st_advance;
        end
        st_advance:
        begin
          first_buf_q <= last_byte_q;
          if (last_byte_q)
          begin
            state_q <= st_write_sop;
          end
          else if (next_is_null)
          begin
            state_q <= st_halted;
          end
          else
          begin
            desc_q <= next_q;
            state_q <= st_fetch_next;
          end
        end
        st_write_sop:
        begin
          if (next_is_null)
          begin
            state_q <= st_halted;
          end
          else
          begin
            desc_q <= next_q;
            state_q <= st_fetch_next;
          end
        end
        st_teardown:
        begin
          state_q <= st_idle;
        end
        default:
        begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_rd_data <= 32'h0000_0000;
      rx_ready <= 1'b0;
      buf_wr_en <= 1'b0;
      buf_wr_addr <= 32'h0000_0000;
      buf_wr_data <= 8'h00;
      channel_active <= 1'b0;
      channel_halted <= 1'b0;
      teardown_done <= 1'b0;
      packet_done <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!engine_reads)
      begin
        host_rd_data <= rd_word;
      end
      rx_ready <= (state_q == st_fetch_len) | (in_fill & ~(byte_take & (rx_last | buf_full)));
      buf_wr_en <= byte_take;
      buf_wr_addr <= buf_ptr_q + {16'h0000, (first_buf_q ? offset_q : 16'h0000)}
                     + {16'h0000, buf_count_q};
      buf_wr_data <= rx_byte;
      channel_active <= (state_q != st_idle) && (state_q != st_halted);
      channel_halted <= (state_q == st_halted);
      teardown_done <= (state_q == st_teardown);
      packet_done <= (state_q == st_write_sop);
    end
  end
endmodule : rx_descriptor_writeback
`default_nettype wire

// ===== include/rx_desc_pkg.sv
// Package of descriptor layout, flag positions and engine states for receive writeback.
package rx_desc_pkg;
  // ==========================================================================
  // Descriptor layout
  // ==========================================================================
  localparam int unsigned desc_words = 4;
  localparam logic [1:0] word_next = 2'h0;
  localparam logic [1:0] word_buf = 2'h1;
  localparam logic [1:0] word_offlen = 2'h2;
  localparam logic [1:0] word_flglen = 2'h3;
  localparam int unsigned addr_width = 32;
  localparam int unsigned mem_index_width = 9;
  localparam int unsigned mem_depth = 2048;
  localparam logic [31:0] null_pointer = 32'h0000_0000;
  localparam int unsigned half_lsb = 0;
  localparam int unsigned half_msb = 16;
  // ==========================================================================
  // Flag bit positions within the flags and length word
  // ==========================================================================
  localparam int unsigned bit_start = 31;
  localparam int unsigned bit_end = 30;
  localparam int unsigned bit_ownership_flag = 29;
  localparam int unsigned bit_eoq = 28;
  localparam int unsigned bit_teardown = 27;
  localparam int unsigned bit_crc_incl = 26;
  localparam int unsigned bit_jabber = 25;
  localparam int unsigned bit_oversize = 24;
  localparam int unsigned bit_fragment = 23;
  localparam int unsigned bit_undersized = 22;
  localparam int unsigned bit_control = 21;
  localparam int unsigned bit_overrun = 20;
  localparam int unsigned bit_symbol = 19;
  localparam int unsigned bit_align = 18;
  localparam int unsigned bit_checksum = 17;
  localparam int unsigned bit_addr_miss = 16;
  localparam logic [15:0] offset_reset = 16'h0000;
  // ==========================================================================
  // Engine states
  // ==========================================================================
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_fetch_next = 4'b0001,
    st_fetch_len = 4'b0010,
    st_fill = 4'b0011,
    st_close_buf = 4'b0100,
    st_write_sop = 4'b0101,
    st_advance = 4'b0110,
    st_teardown = 4'b0111,
    st_halted = 4'b1000
  } engine_state_type;
endpackage : rx_desc_pkg

// ===== test/rx_host_model.sv
// Host software model that builds and reads receive descriptors in local memory.
`timescale 1ns/1ps
`default_nettype none
module rx_host_model
(
  // Clock.
  input wire logic mclk,
  // Local descriptor memory port.
  output logic host_wr_en,
  output logic [31:0] host_addr,
  output logic [31:0] host_wr_data,
  input wire logic [31:0] host_rd_data
);
  initial
  begin
    host_wr_en = 1'b0;
    host_addr = 32'h0000_0000;
    host_wr_data = 32'h0000_0000;
  end
  // Data lines show the inverse after a write so a stale value is never trusted.
  task automatic write_word(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    host_wr_en <= 1'b1;
    host_addr <= a;
    host_wr_data <= d;
    @(posedge mclk);
    host_wr_en <= 1'b0;
    host_wr_data <= ~d;
  endtask : write_word
  task automatic read_word(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    host_addr <= a;
    repeat (2) @(posedge mclk);
    d = host_rd_data;
  endtask : read_word
  // Queues one empty descriptor with all returned fields cleared and ownership given.
  task automatic put_desc(input logic [31:0] a, input logic [31:0] nxt, input logic [15:0] len);
    write_word(a, nxt);
    write_word(a + 32'h0000_0004, {16'h4000, a[15:0]});
    write_word(a + 32'h0000_0008, {16'h0000, len});
    write_word(a + 32'h0000_000c, 32'h2000_0000);
  endtask : put_desc
endmodule : rx_host_model
`default_nettype wire

// ===== test/rx_writeback_sva.sv
// Concurrent checks on the ports of the receive descriptor writeback engine.
`timescale 1ns/1ps
`default_nettype none
module rx_writeback_sva
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Frame stream and offset.
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic rx_ready,
  input wire logic [15:0] receive_offset_value,
  // Buffer writes and status.
  input wire logic buf_wr_en,
  input wire logic [31:0] buf_wr_addr,
  input wire logic [7:0] buf_wr_data,
  input wire logic channel_active,
  input wire logic channel_halted,
  input wire logic teardown_done,
  input wire logic packet_done
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ==================
  // Helper logic
  // ==================
  // Marks that the next buffer write carries the first byte of a packet.
  logic first_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      first_q <= 1'b1;
    else if (packet_done || teardown_done)
      first_q <= 1'b1;
    else if (buf_wr_en)
      first_q <= 1'b0;
  end
  // ==================
  // Properties
  // ==================
  property p_first_offset;
    buf_wr_en && first_q |-> buf_wr_addr == {16'h0000, receive_offset_value};
  endproperty
  a_first_offset: assert property (p_first_offset) else $error("first byte not at offset");
  property p_wr_data;
    buf_wr_en |-> $past(rx_valid) && buf_wr_data == $past(rx_byte);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("buffer byte without taken byte");
  property p_done_after_last;
    rx_valid && rx_last ##1 buf_wr_en |-> ##3 packet_done;
  endproperty
  a_done_after_last: assert property (p_done_after_last) else $error("no packet completion");
  property p_done_pulse;
    packet_done |=> !packet_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("packet completion too long");
  property p_halt_quiet;
    channel_halted |-> !buf_wr_en && !rx_ready && !channel_active;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("halted channel still working");
  property p_teardown_stop;
    teardown_done |=> (!buf_wr_en && !packet_done) [*8];
  endproperty
  a_teardown_stop: assert property (p_teardown_stop) else $error("work after teardown");
  property p_teardown_pulse;
    $rose(teardown_done) |=> $fell(teardown_done);
  endproperty
  a_teardown_pulse: assert property (p_teardown_pulse) else $error("teardown pulse too long");
  property p_no_take_idle;
    !rx_ready && !rx_valid |=> !buf_wr_en;
  endproperty
  a_no_take_idle: assert property (p_no_take_idle) else $error("write with no byte offered");
endmodule : rx_writeback_sva
bind rx_descriptor_writeback rx_writeback_sva rx_writeback_sva_i (.mclk(mclk), .rst_n(rst_n),
  .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last), .rx_ready(rx_ready),
  .receive_offset_value(receive_offset_value), .buf_wr_en(buf_wr_en),
  .buf_wr_addr(buf_wr_addr), .buf_wr_data(buf_wr_data), .channel_active(channel_active),
  .channel_halted(channel_halted), .teardown_done(teardown_done), .packet_done(packet_done));
`default_nettype wire

// ===== test/testbench.sv
// Self-checking testbench for the receive descriptor writeback engine.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rx_desc_pkg::*;
  // ==================
  // Stimulus and observation
  // ==================
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic start_channel = 1'b0;
  logic teardown_request = 1'b0;
  logic [31:0] head_pointer = 32'h0000_0000;
  logic [15:0] receive_offset_value = 16'h0000;
  logic [3:0] keep = 4'h0;
  logic crc_retained = 1'b0;
  logic rx_valid = 1'b0;
  logic rx_last = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [9:0] rx_status = 10'h000;
  logic host_wr_en;
  logic [31:0] host_addr;
  logic [31:0] host_wr_data;
  logic [31:0] host_rd_data;
  logic [31:0] buf_wr_addr;
  logic [7:0] buf_wr_data;
  logic rx_ready;
  logic buf_wr_en;
  logic channel_active;
  logic channel_halted;
  logic teardown_done;
  logic packet_done;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 1;
  int cycles = 0;
  logic [7:0] exp_q[$];
  logic [31:0] addr_q[$];
  always #4 mclk = ~mclk;
  rx_descriptor_writeback rx_descriptor_writeback_i (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
    .head_pointer(head_pointer), .start_channel(start_channel),
    .teardown_request(teardown_request), .receive_offset_value(receive_offset_value),
    .keep_error_frames(keep[0]), .keep_short_frames(keep[1]), .keep_control_frames(keep[2]),
    .keep_all_frames(keep[3]), .crc_retained(crc_retained), .host_wr_en(host_wr_en),
    .host_addr(host_addr), .host_wr_data(host_wr_data), .host_rd_data(host_rd_data),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last), .rx_status(rx_status),
    .rx_ready(rx_ready), .buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr),
    .buf_wr_data(buf_wr_data), .channel_active(channel_active),
    .channel_halted(channel_halted), .teardown_done(teardown_done), .packet_done(packet_done));
  rx_host_model rx_host_model_i (.mclk(mclk), .host_wr_en(host_wr_en), .host_addr(host_addr),
    .host_wr_data(host_wr_data), .host_rd_data(host_rd_data));
  task test_done;
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic fail(input string s);
    n_fail++;
    $display("MISMATCH %0t %s", $time, s);
  endtask : fail
  // Every buffer byte is compared with the model queue as it is written.
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (buf_wr_en === 1'b1)
    begin
      n_tests++;
      if (exp_q.size() == 0)
        fail("unexpected buffer write");
      else if (buf_wr_data !== exp_q.pop_front() || buf_wr_addr !== addr_q.pop_front())
        fail("buffer byte or address");
    end
    if (cycles > 5000)
    begin
      fail("timeout");
      test_done();
    end
  end
  task automatic check_word(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] got;
    rx_host_model_i.read_word(a, got);
    n_tests++;
    if ((got & m) !== (e & m))
      $display("MISMATCH %0t word %h got %h expected %h", $time, a, got, e);
    if ((got & m) !== (e & m))
      n_fail++;
  endtask : check_word
  task automatic send_packet(input int n, input logic [9:0] st);
    int i;
    int w;
    logic [7:0] b;
    for (i = 0; i < n; i++)
    begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      addr_q.push_back({16'h0000, receive_offset_value} + 32'(i));
      w = 0;
      while (i == 0 && rx_ready !== 1'b1 && w < 200)
      begin
        @(posedge mclk);
        w++;
      end
      rx_valid <= 1'b1;
      rx_byte <= b;
      rx_last <= (i == n - 1);
      rx_status <= st;
      @(posedge mclk);
      while (rx_ready !== 1'b1 && w < 200)
      begin
        @(posedge mclk);
        w++;
      end
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask : send_packet
  task automatic wait_flag(input int which);
    int w;
    w = 0;
    while (!((which == 0 && packet_done === 1'b1) || (which == 1 && rx_ready === 1'b1)
      || (which == 1 && channel_halted === 1'b1) || (which == 2 && teardown_done === 1'b1))
      && w < 100)
    begin
      @(posedge mclk);
      w++;
    end
    n_tests++;
    if (w >= 100)
      fail("status never seen");
  endtask : wait_flag
  // ==================
  // Main sequence
  // ==================
  initial
  begin : main
    int k;
    int n;
    logic [9:0] st;
    logic [9:0] m;
    logic [31:0] a;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rx_host_model_i.put_desc(32'h0000_0100, 32'h0000_0110, 16'h0010);
    rx_host_model_i.put_desc(32'h0000_0110, 32'h0000_0000, 16'h0010);
    head_pointer <= 32'h0000_0100;
    receive_offset_value <= 16'($random(seed) & 7);
    start_channel <= 1'b1;
    @(posedge mclk);
    start_channel <= 1'b0;
    for (k = 0; k < 2; k++)
    begin
      a = 32'h0000_0100 + 32'(k * 16);
      n = ($random(seed) & 7) + 1;
      st = 10'($random(seed));
      keep <= 4'($random(seed));
      crc_retained <= 1'($random(seed));
      @(posedge mclk);
      send_packet(n, st);
      wait_flag(0);
      wait_flag(1);
      m = {keep[0], keep[0], keep[0], keep[1], keep[2], 1'b1, keep[0], keep[0], keep[0], keep[3]};
      check_word(a + 32'h0000_0008, {receive_offset_value, 16'(n)}, 32'hffff_ffff);
      check_word(a + 32'h0000_000c, {2'b11, 1'b0, 1'(k), 1'b0, crc_retained, st & m, 16'(n)},
        32'hffff_ffff);
      check_word(a, (k == 0) ? 32'h0000_0110 : 32'h0000_0000, 32'hffff_ffff);
      check_word(a + 32'h0000_0004, {16'h4000, a[15:0]}, 32'hffff_ffff);
    end
    n_tests++;
    if (channel_halted !== 1'b1)
      fail("channel not halted at end of queue");
    rx_host_model_i.put_desc(32'h0000_0120, 32'h0000_0000, 16'h0010);
    head_pointer <= 32'h0000_0120;
    teardown_request <= 1'b1;
    start_channel <= 1'b1;
    @(posedge mclk);
    start_channel <= 1'b0;
    wait_flag(2);
    repeat (10) @(posedge mclk);
    check_word(32'h0000_012c, 32'h0800_0000, 32'h0800_0000);
    test_done();
  end
endmodule : testbench
`default_nettype wire
